// ==== verilog/rcf_pkg.sv ====
// constants for the remote command request framer
package rcf_pkg;
    // frame bytes and codes
    localparam logic [7:0] SOF_BYTE = 8'h7E;
    localparam logic [7:0] TYPE_REQ = 8'h17;
    localparam logic [7:0] TYPE_RSP = 8'h97;
    localparam logic [7:0] CSUM_GOOD = 8'hFF;
    localparam logic [15:0] RSVD_TYPICAL = 16'hFFFE;
    localparam logic [15:0] HDR_LEN = 16'h000F;
    // byte offsets within the frame
    localparam logic [16:0] OFS_LEN_HI = 17'h00001;
    localparam logic [16:0] OFS_LEN_LO = 17'h00002;
    localparam logic [16:0] OFS_TYPE = 17'h00003;
    localparam logic [16:0] OFS_FID = 17'h00004;
    localparam logic [16:0] OFS_DEST = 17'h00005;
    localparam logic [16:0] OFS_DEST_END = 17'h0000C;
    localparam logic [16:0] OFS_RSVD = 17'h0000D;
    localparam logic [16:0] OFS_OPT = 17'h0000F;
    localparam logic [16:0] OFS_CMD = 17'h00010;
    localparam logic [16:0] OFS_CMD_END = 17'h00011;
    localparam logic [16:0] OFS_TAIL = 17'h00003;
    // option bit positions
    localparam int OPT_NO_ACK = 0;
    localparam int OPT_APPLY = 1;
    localparam int OPT_RSVD2 = 2;
    localparam int OPT_RSVD3 = 3;
    localparam int OPT_SECURE = 4;
    // apb byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FCNT = 8'h08;
    localparam logic [7:0] ADDR_DEST_LO = 8'h0C;
    localparam logic [7:0] ADDR_DEST_HI = 8'h10;
    localparam logic [7:0] ADDR_INFO = 8'h14;
    localparam logic [7:0] ADDR_PLEN = 8'h18;
    // control and status fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_SESSION = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int STS_BUSY = 0;
    localparam int STS_LAST_GOOD = 1;
    localparam int STS_ERR_CSUM = 2;
    localparam int STS_ERR_SECURE = 3;
    localparam int STS_ERR_TYPE = 4;
    localparam int STS_ERR_LEN = 5;
    localparam int STS_OPT_RSVD = 6;
    localparam logic [4:0] STICKY_RESET = 5'h00;
    // buffer shape
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 9;
endpackage : rcf_pkg

// ==== verilog/rcf_stream_if.sv ====
// valid/ready byte stream between framer and its buffer
`timescale 1ns/10ps
interface rcf_stream_if #(parameter int W = 9) (input wire logic mclk, input wire logic nrst);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : rcf_stream_if

// ==== verilog/rcf_buffer.sv ====
// two-entry buffer for parameter bytes
`timescale 1ns/10ps
module rcf_buffer #(
    parameter int W = 9,
    parameter int DEPTH = 2
) (
    input wire logic mclk,
    input wire logic nrst,
    rcf_stream_if.snk up,
    rcf_stream_if.src dn
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [AW:0] cnt_r;
    wire push = up.valid && up.ready;
    wire pop = dn.valid && dn.ready;

    // honest full and empty
    assign up.ready = (cnt_r != FULL_CNT);
    assign dn.valid = (cnt_r != '0);
    assign dn.data = mem[rptr_r];

    // pointer wrap helper
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : bump

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wptr_r] <= up.data;
        end
    end

    // pointers and fill level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wptr_r <= bump(wptr_r);
            if (pop) rptr_r <= bump(rptr_r);
            cnt_r <= (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule : rcf_buffer

// ==== verilog/rcf_request_framer.sv ====
// parser for remote command request frames with apb status and control
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - 16-bit length at offset 1 counts bytes between length and checksum.
// - byte at offset 3 is frame type; 0x17 marks a remote request.
// - byte at offset 4 correlates response; zero means no response.
// - reserved word at offset 13 is accepted and never interpreted.
// - option bit 0 sends the remote request without acknowledgment.
// - option bit 1 applies at once; otherwise change stays pending.
// - option bit 4 asks secure delivery; valid only with session established.
// - two bytes at offset 16 name the command as ASCII.
// - bytes from offset 18 to checksum are the value; none means query.
// - checksum is 0xFF minus low byte of sum from offset 3; verified.
// - answer uses response type 0x97 with the same correlation id.
module rcf_request_framer (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] prm_data,
    output logic prm_last,
    output logic prm_valid,
    input wire logic prm_ready,
    output logic req_done,
    output logic req_good,
    output logic req_query,
    output logic req_no_ack,
    output logic req_apply,
    output logic req_secure,
    output logic [7:0] req_frame_id,
    output logic [63:0] req_dest,
    output logic [15:0] req_command,
    output logic [7:0] req_options,
    output logic rsp_needed,
    output logic [7:0] rsp_type
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_LEN = 6'h02,
        ST_HDR = 6'h04,
        ST_PARAM = 6'h08,
        ST_CSUM = 6'h10,
        ST_SKIP = 6'h20
    } rcf_state_t;

    rcf_state_t st_r;
    rcf_state_t st_nxt;
    logic [16:0] pos_r;
    logic [15:0] len_r;
    logic [7:0] sum_r;
    logic [7:0] fid_r;
    logic [63:0] dest_r;
    logic [7:0] opt_r;
    logic [15:0] cmd_r;
    logic [1:0] ctrl_r;
    logic [4:0] sticky_r;
    logic [4:0] sticky_nxt;
    logic [31:0] fcnt_r;
    logic [15:0] plen_r;
    logic last_good_r;

    // shared parameter byte stream carriers
    rcf_stream_if #(.W(rcf_pkg::BUF_WIDTH)) fill (.mclk(mclk), .nrst(nrst));
    rcf_stream_if #(.W(rcf_pkg::BUF_WIDTH)) drain (.mclk(mclk), .nrst(nrst));

    rcf_buffer #(.W(rcf_pkg::BUF_WIDTH), .DEPTH(rcf_pkg::BUF_DEPTH)) u_buf (
        .mclk(mclk),
        .nrst(nrst),
        .up(fill.snk),
        .dn(drain.src)
    );

    // offset range test used by two field decodes
    function automatic logic in_span(input logic [16:0] p, input logic [16:0] lo, input logic [16:0] hi);
        in_span = (p >= lo) && (p <= hi);
    endfunction : in_span

    // frame position decode
    wire [16:0] end_pos = {1'b0, len_r} + rcf_pkg::OFS_TAIL; // checksum offset
    wire [16:0] last_prm_pos = 17'(end_pos - 17'h00001);
    wire [15:0] len_full = {len_r[7:0], rx_data};
    wire len_short = len_full < rcf_pkg::HDR_LEN;
    wire type_bad = rx_data != rcf_pkg::TYPE_REQ;
    wire sof_seen = (rx_data == rcf_pkg::SOF_BYTE) && ctrl_r[rcf_pkg::CTRL_EN];
    wire hdr_only = (len_r == rcf_pkg::HDR_LEN); // no value bytes means query
    wire csum_ok = 8'(sum_r + rx_data) == rcf_pkg::CSUM_GOOD;
    wire secure_bad = opt_r[rcf_pkg::OPT_SECURE] && !ctrl_r[rcf_pkg::CTRL_SESSION];
    wire frame_good = csum_ok && !secure_bad;

    // byte acceptance; value bytes stall on a full buffer
    assign rx_ready = (st_r != ST_PARAM) || fill.ready;
    wire rx_fire = rx_valid && rx_ready;
    assign fill.valid = (st_r == ST_PARAM) && rx_valid;
    assign fill.data = {pos_r == last_prm_pos, rx_data};
    assign drain.ready = prm_ready;
    assign prm_valid = drain.valid;
    assign prm_data = drain.data[7:0];
    assign prm_last = drain.data[8];

    // next state on each accepted byte
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: if (sof_seen) st_nxt = ST_LEN;
            ST_LEN: if (pos_r == rcf_pkg::OFS_LEN_LO) st_nxt = len_short ? ST_SKIP : ST_HDR;
            ST_HDR: begin
                if (pos_r == rcf_pkg::OFS_TYPE && type_bad) begin
                    st_nxt = ST_SKIP;
                end else if (pos_r == rcf_pkg::OFS_CMD_END) begin
                    st_nxt = hdr_only ? ST_CSUM : ST_PARAM;
                end
            end
            ST_PARAM: if (pos_r == last_prm_pos) st_nxt = ST_CSUM;
            ST_CSUM: st_nxt = ST_IDLE;
            ST_SKIP: if (pos_r == end_pos) st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    // state and position
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            pos_r <= '0;
        end else if (rx_fire) begin
            st_r <= st_nxt;
            pos_r <= (st_r == ST_IDLE) ? rcf_pkg::OFS_LEN_HI : 17'(pos_r + 17'h00001);
        end
    end

    // field capture by offset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            len_r <= '0;
            sum_r <= '0;
            fid_r <= '0;
            dest_r <= '0;
            opt_r <= '0;
            cmd_r <= '0;
        end else if (rx_fire && st_r == ST_LEN) begin
            len_r <= {len_r[7:0], rx_data};
        end else if (rx_fire && (st_r == ST_HDR || st_r == ST_PARAM)) begin
            sum_r <= (pos_r == rcf_pkg::OFS_TYPE) ? rx_data : 8'(sum_r + rx_data);
            if (pos_r == rcf_pkg::OFS_FID) fid_r <= rx_data;
            if (in_span(pos_r, rcf_pkg::OFS_DEST, rcf_pkg::OFS_DEST_END)) begin
                dest_r <= {dest_r[55:0], rx_data}; // taken as sent, all ones allowed
            end
            // offsets 13 and 14 only feed the checksum
            if (pos_r == rcf_pkg::OFS_OPT) opt_r <= rx_data;
            if (in_span(pos_r, rcf_pkg::OFS_CMD, rcf_pkg::OFS_CMD_END)) begin
                cmd_r <= {cmd_r[7:0], rx_data};
            end
        end
    end

    // request result, held until the next completed frame; req_done pulses for one cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_done <= 1'b0;
            req_good <= 1'b0;
            req_query <= 1'b0;
            req_no_ack <= 1'b0;
            req_apply <= 1'b0;
            req_secure <= 1'b0;
            req_frame_id <= '0;
            req_dest <= '0;
            req_command <= '0;
            req_options <= '0;
            rsp_needed <= 1'b0;
            rsp_type <= rcf_pkg::TYPE_RSP;
            plen_r <= '0;
        end else begin
            req_done <= rx_fire && st_r == ST_CSUM;
            if (rx_fire && st_r == ST_CSUM) begin
                req_good <= frame_good;
                req_query <= hdr_only;
                req_no_ack <= opt_r[rcf_pkg::OPT_NO_ACK];
                req_apply <= opt_r[rcf_pkg::OPT_APPLY]; // pending when clear
                req_secure <= opt_r[rcf_pkg::OPT_SECURE];
                req_frame_id <= fid_r;
                req_dest <= dest_r;
                req_command <= cmd_r;
                req_options <= opt_r;
                rsp_needed <= frame_good && (fid_r != 8'h00);
                rsp_type <= rcf_pkg::TYPE_RSP;
                plen_r <= 16'(len_r - rcf_pkg::HDR_LEN);
            end
        end
    end

    // apb decode
    wire apb_setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire hit_ctrl = paddr == rcf_pkg::ADDR_CTRL;
    wire hit_sts = paddr == rcf_pkg::ADDR_STATUS;
    wire addr_ok = hit_ctrl || hit_sts || (paddr == rcf_pkg::ADDR_FCNT) || (paddr == rcf_pkg::ADDR_DEST_LO) ||
        (paddr == rcf_pkg::ADDR_DEST_HI) || (paddr == rcf_pkg::ADDR_INFO) || (paddr == rcf_pkg::ADDR_PLEN);
    wire [4:0] sticky_clr = (apb_wr && hit_sts) ? pwdata[6:2] : 5'h00;
    wire done_now = rx_fire && st_r == ST_CSUM;
    wire [4:0] sticky_set = {
        done_now && (opt_r[rcf_pkg::OPT_RSVD3] || opt_r[rcf_pkg::OPT_RSVD2]), // host broke zero bits
        rx_fire && st_r == ST_LEN && pos_r == rcf_pkg::OFS_LEN_LO && len_short,
        rx_fire && st_r == ST_HDR && pos_r == rcf_pkg::OFS_TYPE && type_bad,
        done_now && secure_bad,
        done_now && !csum_ok
    };
    assign sticky_nxt = (sticky_r & ~sticky_clr) | sticky_set; // set wins over clear
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // read data mux
    logic [31:0] rd_mux;
    always_comb begin
        case (paddr)
            rcf_pkg::ADDR_CTRL: rd_mux = {30'h00000000, ctrl_r};
            rcf_pkg::ADDR_STATUS: rd_mux = {25'h0000000, sticky_r, last_good_r, st_r != ST_IDLE};
            rcf_pkg::ADDR_FCNT: rd_mux = fcnt_r;
            rcf_pkg::ADDR_DEST_LO: rd_mux = req_dest[31:0];
            rcf_pkg::ADDR_DEST_HI: rd_mux = req_dest[63:32];
            rcf_pkg::ADDR_INFO: rd_mux = {req_command, req_options, req_frame_id};
            rcf_pkg::ADDR_PLEN: rd_mux = {16'h0000, plen_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // apb registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= rcf_pkg::CTRL_RESET;
            sticky_r <= rcf_pkg::STICKY_RESET;
            fcnt_r <= '0;
            last_good_r <= 1'b0;
            prdata <= '0;
        end else begin
            if (apb_wr && hit_ctrl) ctrl_r <= pwdata[1:0];
            sticky_r <= sticky_nxt;
            if (done_now) last_good_r <= frame_good;
            if (done_now && frame_good) fcnt_r <= 32'(fcnt_r + 32'h00000001);
            if (apb_setup) prdata <= rd_mux;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence s_sof;
        st_r == ST_IDLE && rx_fire && sof_seen;
    endsequence
    sequence s_len_short;
        rx_fire && st_r == ST_LEN && pos_r == rcf_pkg::OFS_LEN_LO && len_short;
    endsequence

    property p_resync;
        s_sof |=> st_r == ST_LEN && pos_r == rcf_pkg::OFS_LEN_HI;
    endproperty
    a_resync: assert property (p_resync) else $error("start byte not taken");

    property p_short_len;
        s_len_short |=> st_r == ST_SKIP && sticky_r[3];
    endproperty
    a_short_len: assert property (p_short_len) else $error("short length not skipped");

    property p_bad_type;
        rx_fire && st_r == ST_HDR && pos_r == rcf_pkg::OFS_TYPE && type_bad |=> st_r == ST_SKIP ##0 !req_done;
    endproperty
    a_bad_type: assert property (p_bad_type) else $error("foreign frame type parsed");

    property p_no_rsp_zero_id;
        req_done && req_frame_id == 8'h00 |-> !rsp_needed;
    endproperty
    a_no_rsp_zero_id: assert property (p_no_rsp_zero_id) else $error("response for zero id");

    property p_csum;
        rx_fire && st_r == ST_CSUM && !csum_ok |=> req_done && !req_good && sticky_r[0];
    endproperty
    a_csum: assert property (p_csum) else $error("bad checksum accepted");

    property p_secure;
        req_done && req_secure && !ctrl_r[rcf_pkg::CTRL_SESSION] |-> !req_good;
    endproperty
    a_secure: assert property (p_secure) else $error("secure without session");

    property p_query;
        req_done |-> req_query == (plen_r == 16'h0000);
    endproperty
    a_query: assert property (p_query) else $error("query flag wrong");

    property p_rsp;
        req_done && rsp_needed |-> rsp_type == 8'h97 && req_frame_id == $past(fid_r) && req_good;
    endproperty
    a_rsp: assert property (p_rsp) else $error("response type or id wrong");

    property p_stall;
        st_r == ST_PARAM && rx_valid && !fill.ready |=> $stable(pos_r) && st_r == ST_PARAM;
    endproperty
    a_stall: assert property (p_stall) else $error("value byte taken while buffer full");

    // one header byte taken at a given offset
    sequence s_hdr_take(logic [16:0] p);
        rx_fire && st_r == ST_HDR && pos_r == p;
    endsequence

    property p_len_take;
        rx_fire && st_r == ST_LEN && pos_r == rcf_pkg::OFS_LEN_LO |=> len_r == $past(len_full);
    endproperty
    a_len_take: assert property (p_len_take) else $error("length not captured");

    property p_skip_end;
        rx_fire && st_r == ST_SKIP && pos_r == end_pos |=> st_r == ST_IDLE;
    endproperty
    a_skip_end: assert property (p_skip_end) else $error("skip overran checksum slot");

    property p_sum_start;
        s_hdr_take(rcf_pkg::OFS_TYPE) |=> sum_r == $past(rx_data);
    endproperty
    a_sum_start: assert property (p_sum_start) else $error("sum not restarted at type");

    property p_fid_take;
        s_hdr_take(rcf_pkg::OFS_FID) |=> fid_r == $past(rx_data);
    endproperty
    a_fid_take: assert property (p_fid_take) else $error("frame id not captured");

    property p_opt_take;
        s_hdr_take(rcf_pkg::OFS_OPT) |=> opt_r == $past(rx_data);
    endproperty
    a_opt_take: assert property (p_opt_take) else $error("options not captured");

    property p_cmd_take;
        s_hdr_take(rcf_pkg::OFS_CMD_END) |=> cmd_r == {$past(cmd_r[7:0]), $past(rx_data)};
    endproperty
    a_cmd_take: assert property (p_cmd_take) else $error("command not captured");

    property p_last_flag;
        fill.valid && fill.ready && fill.data[8] |=> st_r == ST_CSUM;
    endproperty
    a_last_flag: assert property (p_last_flag) else $error("last value flag misplaced");
endmodule : rcf_request_framer

// ==== tb/rcf_host_model.sv ====
// host model: feeds request bytes and drains value bytes
`timescale 1ns/10ps
module rcf_host_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic rx_ready,
    input wire logic [7:0] prm_data,
    input wire logic prm_last,
    input wire logic prm_valid,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic prm_ready
);
    logic [7:0] tx_q[$]; // bytes waiting to go out
    logic [8:0] got_q[$]; // {last, data} taken from the value stream
    int stall_pct = 0; // share of cycles with prm_ready low
    // idle values at time zero
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        prm_ready = 1'b1;
    end
    // byte held until taken; idle line shows inverted data so stale bytes never look valid
    always @(posedge mclk) begin
        if (rx_valid && rx_ready) begin
            void'(tx_q.pop_front());
        end
        if (prm_valid && prm_ready) begin
            got_q.push_back({prm_last, prm_data});
        end
        prm_ready <= ($urandom_range(99) >= stall_pct);
        if (rx_valid && !rx_ready) begin
            rx_valid <= 1'b1;
        end else if (nrst && tx_q.size() > 0 && $urandom_range(3) != 0) begin
            rx_valid <= 1'b1;
            rx_data <= tx_q[0];
        end else begin
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
        end
    end
endmodule : rcf_host_model

// ==== tb/tb_top.sv ====
// self-checking bench for the request framer
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] SHORT_FR [8] = '{8'h7E, 8'h00, 8'h04, 8'h17, 8'h01, 8'h02, 8'h03, 8'hE2};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rx_ready, rx_valid, prm_last, prm_valid, prm_ready, err;
    logic [7:0] rx_data, prm_data, req_frame_id, req_options, rsp_type;
    logic req_done, req_good, req_query, req_no_ack, req_apply, req_secure, rsp_needed;
    logic [63:0] req_dest;
    logic [15:0] req_command;
    logic [8:0] exp_val[$];
    logic session = 1'b0;
    int bad_count = 0;
    int n_compared = 0;
    int done_cnt = 0;
    int exp_done = 0;
    int exp_cnt = 0;

    always #50 mclk = ~mclk;

    rcf_request_framer dut_u (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .prm_data(prm_data), .prm_last(prm_last),
        .prm_valid(prm_valid), .prm_ready(prm_ready), .req_done(req_done), .req_good(req_good),
        .req_query(req_query), .req_no_ack(req_no_ack), .req_apply(req_apply), .req_secure(req_secure),
        .req_frame_id(req_frame_id), .req_dest(req_dest), .req_command(req_command),
        .req_options(req_options), .rsp_needed(rsp_needed), .rsp_type(rsp_type));
    rcf_host_model host_u (.mclk(mclk), .nrst(nrst), .rx_ready(rx_ready), .prm_data(prm_data),
        .prm_last(prm_last), .prm_valid(prm_valid), .rx_data(rx_data), .rx_valid(rx_valid), .prm_ready(prm_ready));

    // count completion pulses
    always @(posedge mclk) begin
        if (req_done === 1'b1) done_cnt++;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        check(what, rd & m, exp);
    endtask : rchk

    // status and count check, then sticky clear by writing ones
    task automatic stat_chk(input logic [31:0] exp, input logic [31:0] m);
        rchk("status", rcf_pkg::ADDR_STATUS, exp, m);
        rchk("fcnt", rcf_pkg::ADDR_FCNT, exp_cnt, 32'hFFFFFFFF);
        apb(1'b1, rcf_pkg::ADDR_STATUS, 32'h7C);
        rchk("sticky clear", rcf_pkg::ADDR_STATUS, 32'h0, 32'h7C);
    endtask : stat_chk

    task automatic send_frame(input logic [7:0] typ, input logic [7:0] fid, input logic [63:0] dest,
            input logic [7:0] opt, input logic [15:0] cmd, input int nval, input logic bad_sum);
        logic [7:0] b[$];
        logic [7:0] sum;
        logic [15:0] len;
        int i;
        b = {typ, fid};
        for (i = 7; i >= 0; i--) b.push_back(dest[i*8 +: 8]);
        b.push_back(8'hFF);
        b.push_back(8'hFE);
        b.push_back(opt);
        b.push_back(cmd[15:8]);
        b.push_back(cmd[7:0]);
        exp_val.delete();
        for (i = 0; i < nval; i++) begin
            b.push_back(8'($urandom));
            exp_val.push_back({i == nval - 1, b[b.size() - 1]});
        end
        sum = 8'h00;
        foreach (b[k]) sum += b[k];
        len = 16'(b.size());
        b.push_back((8'hFF - sum) ^ {8{bad_sum}});
        if ($urandom_range(1) == 1) host_u.tx_q.push_back(8'h55);
        host_u.tx_q.push_back(rcf_pkg::SOF_BYTE);
        host_u.tx_q.push_back(len[15:8]);
        host_u.tx_q.push_back(len[7:0]);
        foreach (b[k]) host_u.tx_q.push_back(b[k]);
    endtask : send_frame

    task automatic wait_idle();
        int i;
        for (i = 0; i < 3000; i++) begin
            if (host_u.tx_q.size() == 0 && done_cnt == exp_done && host_u.got_q.size() >= exp_val.size()) break;
            @(posedge mclk);
        end
        if (i == 3000) bad_count++;
        repeat (4) @(posedge mclk);
        check("req_done count", done_cnt, exp_done);
    endtask : wait_idle

    task automatic frame_test(input logic [7:0] fid, input logic [63:0] dest, input logic [7:0] opt,
            input int nval, input logic bad_sum);
        logic [15:0] cmd;
        logic good;
        cmd = {8'h41 + 8'($urandom_range(25)), 8'h41 + 8'($urandom_range(25))};
        good = !bad_sum && !(opt[rcf_pkg::OPT_SECURE] && !session);
        host_u.got_q.delete();
        send_frame(rcf_pkg::TYPE_REQ, fid, dest, opt, cmd, nval, bad_sum);
        exp_done++;
        exp_cnt += good;
        if (host_u.stall_pct == 100) begin
            repeat (60) @(posedge mclk);
            check("rx_ready stalled", rx_ready, 1'b0);
            host_u.stall_pct = 30;
        end
        wait_idle();
        check("req_good", req_good, good);
        check("req_query", req_query, nval == 0);
        check("req_no_ack", req_no_ack, opt[0]);
        check("req_apply", req_apply, opt[1]);
        check("req_secure", req_secure, opt[4]);
        check("req_frame_id", req_frame_id, fid);
        check("req_dest", req_dest, dest);
        check("req_command", req_command, cmd);
        check("req_options", req_options, opt);
        check("rsp_needed", rsp_needed, good && fid != 8'h00);
        check("rsp_type", rsp_type, rcf_pkg::TYPE_RSP);
        check("value count", host_u.got_q.size(), nval);
        foreach (exp_val[k]) check("value byte", host_u.got_q[k], exp_val[k]);
        rchk("dest lo", rcf_pkg::ADDR_DEST_LO, dest[31:0], 32'hFFFFFFFF);
        rchk("dest hi", rcf_pkg::ADDR_DEST_HI, dest[63:32], 32'hFFFFFFFF);
        rchk("info", rcf_pkg::ADDR_INFO, {cmd, opt, fid}, 32'hFFFFFFFF);
        rchk("plen", rcf_pkg::ADDR_PLEN, nval, 32'hFFFFFFFF);
        stat_chk({25'h0, opt[3:2] != 2'b00, 2'b00, opt[4] && !session, bad_sum, good, 1'b0}, 32'h7F);
    endtask : frame_test

    // watchdog
    initial begin
        #5000000;
        bad_count++;
        results();
    end

    // main sequence: reset values, corner frames, refused frames, random frames
    initial begin
        logic [7:0] opt;
        logic bs;
        void'($urandom(32'h07d90970));
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        rchk("ctrl reset", rcf_pkg::ADDR_CTRL, 32'(rcf_pkg::CTRL_RESET), 32'h3);
        stat_chk(32'h0, 32'h7F);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        frame_test(8'h00, 64'hFFFFFFFFFFFFFFFF, 8'h00, 0, 1'b0);
        frame_test(8'h27, {$urandom, $urandom}, 8'h10, 3, 1'b0);
        apb(1'b1, rcf_pkg::ADDR_CTRL, 32'h3);
        session = 1'b1;
        host_u.stall_pct = 100;
        frame_test(8'h55, {$urandom, $urandom}, 8'h13, 6, 1'b0);
        frame_test(8'h01, {$urandom, $urandom}, 8'h0C, 1, 1'b0);
        frame_test(8'h68, {$urandom, $urandom}, 8'h02, 2, 1'b1);
        send_frame(8'h10, 8'h11, {$urandom, $urandom}, 8'h00, 16'h5450, 0, 1'b0);
        wait_idle();
        stat_chk(32'h10, 32'h7C);
        foreach (SHORT_FR[k]) host_u.tx_q.push_back(SHORT_FR[k]);
        wait_idle();
        stat_chk(32'h20, 32'h7C);
        apb(1'b1, rcf_pkg::ADDR_CTRL, 32'h2);
        send_frame(rcf_pkg::TYPE_REQ, 8'h12, {$urandom, $urandom}, 8'h00, 16'h5450, 0, 1'b0);
        wait_idle();
        stat_chk(32'h0, 32'h7C);
        for (int n = 0; n < 12; n++) begin
            session = 1'($urandom_range(1));
            apb(1'b1, rcf_pkg::ADDR_CTRL, {30'h0, session, 1'b1});
            host_u.stall_pct = $urandom_range(70);
            bs = ($urandom_range(7) == 0);
            opt = 8'($urandom) & {3'h0, !bs, 4'h3};
            frame_test(8'($urandom), {$urandom, $urandom}, opt, $urandom_range(6), bs);
        end
        results();
    end
endmodule : tb_top
